/* File: rtl/otp_pkg.sv */
// constants, field layout and helpers shared by both trimming link ends
package otp_pkg;
   localparam int           FRAME_BITS  = 24;
   localparam logic [4:0]   LAST_BIT    = 5'h17;
   localparam logic [1:0]   PFX_WRITE   = 2'h0;
   localparam logic [1:0]   PFX_READ    = 2'h1;
   localparam logic [5:0]   TRIM_ADDR   = 6'h3e;
   localparam logic [2:0]   CODE_NONE   = 3'h0;
   localparam logic [2:0]   CODE_STD    = 3'h1;
   localparam logic [2:0]   CODE_MARGIN = 3'h2;
   localparam logic [2:0]   CODE_BLANK  = 3'h3;
   localparam logic [2:0]   CODE_BURN   = 3'h4;
   localparam logic [2:0]   CODE_EOT    = 3'h7;
   // command frame fields
   localparam int           F_PFX_MSB   = 23;
   localparam int           F_PFX_LSB   = 22;
   localparam int           F_ADDR_MSB  = 21;
   localparam int           F_ADDR_LSB  = 16;
   localparam int           F_CODE_MSB  = 15;
   localparam int           F_CODE_LSB  = 13;
   localparam int           F_WORD_MSB  = 12;
   localparam int           F_WORD_LSB  = 5;
   // trimming register image, as answered on reads
   localparam int           R_WORD_MSB  = 20;
   localparam int           R_WORD_LSB  = 13;
   localparam int           R_LOCK      = 12;
   localparam logic [7:0]   RESET_WORD  = 8'h01;
   localparam int           BLANK_MSB   = 5;
   localparam int           BLANK_LSB   = 2;
   // antifuse model: burn count needed to read as written
   localparam int           FUSE_IDX_W  = 8;
   localparam logic [1:0]   THR_STD     = 2'h1;
   localparam logic [1:0]   THR_BLANK   = 2'h1;
   localparam logic [1:0]   THR_MARGIN  = 2'h2;
   localparam logic [1:0]   FUSE_MAX    = 2'h3;
   // link timing
   localparam logic [2:0]   HALF_M1     = 3'h7;
   localparam logic [20:0]  GAP_CYC     = 21'h000010;
   localparam int           CNT_W       = 21;
   localparam real          CLK_NS      = 4.0;
   localparam real          T_BURN_BASE_US = 2.85;
   localparam real          T_BURN_BIT_US  = 401.0;
   localparam real          T_EOT_US       = 404.0;
   localparam int BURN_BASE_CYC = int'($ceil(T_BURN_BASE_US * 1000.0 / CLK_NS));
   localparam int BURN_BIT_CYC  = int'($ceil(T_BURN_BIT_US * 1000.0 / CLK_NS));
   localparam int EOT_CYC       = int'($ceil(T_EOT_US * 1000.0 / CLK_NS));

   function automatic logic odd_par(input logic [22:0] x);
      return ~^x;
   endfunction

   function automatic logic par_ok(input logic [23:0] x);
      return ^x;
   endfunction

   function automatic logic [3:0] popcnt(input logic [7:0] w);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, w[i]};
      end
      return n;
   endfunction

   function automatic logic [CNT_W-1:0] burn_cyc(input logic [7:0] w, input int bit_cyc);
      return CNT_W'(BURN_BASE_CYC + bit_cyc * int'(popcnt(w)));
   endfunction
endpackage

/* File: rtl/otp_spi_if.sv */
// serial link between trimming master and device
`timescale 1ns/10ps
interface otp_spi_if;
   logic sck;
   logic csn_n;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;

   // undriven line idles high
   assign sdo = sdo_oe ? sdo_o : 1'b1;

   modport device (input sck, input csn_n, input sdi, output sdo_o, output sdo_oe);
   modport host (output sck, output csn_n, output sdi, input sdo);
endinterface

/* File: rtl/otp_trim_dev.sv */
// device end: trimming register, antifuse model and burn timing
`timescale 1ns/10ps
module otp_trim_dev #(
   parameter int P_BURN_BIT_CYC = otp_pkg::BURN_BIT_CYC,
   parameter int P_EOT_CYC      = otp_pkg::EOT_CYC
) (
   input  wire logic       I_MCLK,
   input  wire logic       I_RESET,
   output logic [7:0]      O_TRIM_WORD,
   output logic            O_LOCKED,
   output logic            O_BURN_BUSY,
   output logic            O_FRAME_ERR,
   otp_spi_if.device       SPI
);
   logic [2:0]                  sck_s_q;
   logic [2:0]                  csn_s_q;
   logic [1:0]                  sdi_s_q;
   logic [23:0]                 rx_q;
   logic [23:0]                 tx_q;
   logic [4:0]                  cnt_q;
   logic [2:0]                  code_q;
   logic [7:0]                  word_q;
   logic [7:0]                  sel_q;
   logic                        kind_eot_q;
   logic [otp_pkg::CNT_W-1:0]   tmr_q;
   logic [8:0][1:0]             fuse_q;
   logic [7:0]                  trim_q;
   logic                        err_q;

   function automatic logic [7:0] fuse_read(input logic [8:0][1:0] f, input logic [1:0] thr);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = (f[i] >= thr);
      end
      return r;
   endfunction

   wire        sck_rise  = sck_s_q[1] & ~sck_s_q[2];
   wire        sck_fall  = ~sck_s_q[1] & sck_s_q[2];
   wire        csn_fall  = ~csn_s_q[1] & csn_s_q[2];
   wire        csn_rise  = csn_s_q[1] & ~csn_s_q[2];
   wire        selected  = ~csn_s_q[1];
   wire        busy      = (tmr_q != '0);
   wire        locked    = (fuse_q[otp_pkg::FUSE_IDX_W] >= otp_pkg::THR_STD);
   wire        frame_ok  = (cnt_q == otp_pkg::LAST_BIT + 5'h1) && otp_pkg::par_ok(rx_q);      // [RL15]
   wire        addr_ok   = (rx_q[otp_pkg::F_ADDR_MSB:otp_pkg::F_ADDR_LSB] == otp_pkg::TRIM_ADDR);
   wire        is_write  = (rx_q[otp_pkg::F_PFX_MSB:otp_pkg::F_PFX_LSB] == otp_pkg::PFX_WRITE);
   wire        do_write  = csn_rise && frame_ok && addr_ok && is_write && !busy;
   wire [2:0]  rx_code   = rx_q[otp_pkg::F_CODE_MSB:otp_pkg::F_CODE_LSB];
   wire [7:0]  rx_word   = rx_q[otp_pkg::F_WORD_MSB:otp_pkg::F_WORD_LSB];
   wire        burn_go   = do_write && (rx_code == otp_pkg::CODE_BURN) && !locked;               // [RL13]
   wire        eot_go    = do_write && (rx_code == otp_pkg::CODE_EOT);                          // [RL9]
   wire        read_go   = do_write && ((rx_code == otp_pkg::CODE_STD) || (rx_code == otp_pkg::CODE_MARGIN)
                                        || (rx_code == otp_pkg::CODE_BLANK));                   // [RL12]
   wire [1:0]  read_thr  = (rx_code == otp_pkg::CODE_MARGIN) ? otp_pkg::THR_MARGIN :            // [RL14]
                           (rx_code == otp_pkg::CODE_BLANK) ? otp_pkg::THR_BLANK :              // [RL2]
                           otp_pkg::THR_STD;
   wire [22:0] image_hi  = {code_q, word_q, locked, 11'h000};
   wire [23:0] image     = {image_hi, otp_pkg::odd_par(image_hi)};                              // [RL15]

   assign SPI.sdo_o  = tx_q[23];
   assign SPI.sdo_oe = selected;
   assign O_TRIM_WORD = trim_q;
   assign O_LOCKED    = locked;                                                                 // [RL9]
   assign O_BURN_BUSY = busy;
   assign O_FRAME_ERR = err_q;

   always_ff @(posedge I_MCLK) begin
      sck_s_q <= {sck_s_q[1:0], SPI.sck};
      csn_s_q <= {csn_s_q[1:0], SPI.csn_n};
      sdi_s_q <= {sdi_s_q[0], SPI.sdi};
   end

   // serial shift in and answer shift out
   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         rx_q  <= '0;
         tx_q  <= '0;
         cnt_q <= '0;
         err_q <= 1'b0;
      end else begin
         err_q <= csn_rise && (cnt_q != '0) && !frame_ok;
         if (csn_fall) begin
            tx_q  <= image;                                                                     // [RL3]
            cnt_q <= '0;
         end else if (selected && sck_fall) begin
            tx_q <= {tx_q[22:0], 1'b0};
         end
         if (selected && sck_rise) begin
            rx_q <= {rx_q[22:0], sdi_s_q[1]};
            if (cnt_q != 5'h1f) begin
               cnt_q <= cnt_q + 5'h1;
            end
         end
      end
   end

   // register content, burn timer and antifuses
   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         code_q     <= otp_pkg::CODE_NONE;
         word_q     <= otp_pkg::RESET_WORD;
         sel_q      <= '0;
         kind_eot_q <= 1'b0;
         tmr_q      <= '0;
         fuse_q     <= '0;
         trim_q     <= '0;
      end else begin
         trim_q <= fuse_read(fuse_q, otp_pkg::THR_STD);
         if (read_go) begin
            code_q <= rx_code;
            word_q <= fuse_read(fuse_q, read_thr);                                              // [RL2] [RL14]
         end else if (burn_go) begin
            code_q     <= rx_code;
            word_q     <= rx_word;
            sel_q      <= rx_word;
            kind_eot_q <= 1'b0;
            tmr_q      <= otp_pkg::burn_cyc(rx_word, P_BURN_BIT_CYC);                           // [RL6] [RL8]
         end else if (eot_go) begin
            code_q     <= rx_code;
            kind_eot_q <= 1'b1;
            tmr_q      <= otp_pkg::CNT_W'(P_EOT_CYC);                                           // [RL9]
         end else if (busy) begin
            tmr_q <= tmr_q - otp_pkg::CNT_W'(1);
         end
         // fuses take the burn at the end of its time
         if (tmr_q == otp_pkg::CNT_W'(1)) begin
            for (int i = 0; i < 8; i++) begin
               if (!kind_eot_q && sel_q[i] && (fuse_q[i] != otp_pkg::FUSE_MAX)) begin
                  fuse_q[i] <= fuse_q[i] + 2'h1;                                                // [RL6]
               end
            end
            if (kind_eot_q && (fuse_q[otp_pkg::FUSE_IDX_W] != otp_pkg::FUSE_MAX)) begin
               fuse_q[otp_pkg::FUSE_IDX_W] <= fuse_q[otp_pkg::FUSE_IDX_W] + 2'h1;               // [RL9]
            end
         end
      end
   end
endmodule

/* File: rtl/otp_trim_host.sv */
// master end: runs the whole customer trimming flow over the serial link
// Function
// RL1: flow opens with blank check before burning
// RL2: blank check load: write code 011, zero payload
// RL3: each load followed by read frame, device answers
// RL4: reject unless blank readback matches xx0000xx
// RL5: chosen 8-bit default word maps onto bits 20..13
// RL6: burn write carries code 100 and word
// RL7: burn write issued three times in a row
// RL8: burn lasts 2.85 us plus 401 us per bit
// RL9: three end-of-trimming writes, 404 us each
// RL10: verify burned bits with margin mode read
// RL11: final blank check confirms unburned cells intact
// RL12: codes: 001 std, 010 margin, 011 blank, 100, 111
// RL13: content written only for burn code, unlocked
// RL14: margin load compares at lower resistance
// RL15: bit 0 of each frame is odd parity
`timescale 1ns/10ps
module otp_trim_host #(
   parameter int P_BURN_BIT_CYC = otp_pkg::BURN_BIT_CYC,
   parameter int P_EOT_CYC      = otp_pkg::EOT_CYC
) (
   input  wire logic       I_MCLK,
   input  wire logic       I_RESET,
   input  wire logic       I_START,
   input  wire logic [7:0] I_WORD,
   output logic            O_BUSY,
   output logic            O_PASS,
   output logic            O_FAIL,
   output logic [3:0]      O_FAIL_STEP,
   output logic [23:0]     O_RD_DATA,
   otp_spi_if.host         SPI
);
   typedef enum logic [6:0] {
      S_IDLE  = 7'b0000001,
      S_LOAD  = 7'b0000010,
      S_SEND  = 7'b0000100,
      S_GAP   = 7'b0001000,
      S_WAIT  = 7'b0010000,
      S_CHECK = 7'b0100000,
      S_DONE  = 7'b1000000
   } otp_hst_t;

   // flow steps, in the order they run
   localparam logic [3:0] ST_BLANK_LD  = 4'h0;
   localparam logic [3:0] ST_BLANK_RD  = 4'h1;
   localparam logic [3:0] ST_BURN_A    = 4'h2;
   localparam logic [3:0] ST_BURN_Z    = 4'h4;
   localparam logic [3:0] ST_EOT_A     = 4'h5;
   localparam logic [3:0] ST_EOT_Z     = 4'h7;
   localparam logic [3:0] ST_MARGIN_LD = 4'h8;
   localparam logic [3:0] ST_MARGIN_RD = 4'h9;
   localparam logic [3:0] ST_FINAL_LD  = 4'ha;
   localparam logic [3:0] ST_FINAL_RD  = 4'hb;

   otp_hst_t                    st_q;
   logic [3:0]                  step_q;
   logic [7:0]                  word_q;
   logic [23:0]                 shift_q;
   logic [23:0]                 rx_q;
   logic [23:0]                 rd_q;
   logic [4:0]                  bit_q;
   logic [2:0]                  div_q;
   logic [otp_pkg::CNT_W-1:0]   wait_q;
   logic                        sck_q;
   logic                        csn_n_q;
   logic                        sdo_s1_q;
   logic                        sdo_s2_q;
   logic                        busy_q;
   logic                        pass_q;
   logic                        fail_q;
   logic [3:0]                  fstep_q;

   wire        step_is_read = (step_q == ST_BLANK_RD) || (step_q == ST_MARGIN_RD)
                              || (step_q == ST_FINAL_RD);                                       // [RL3]
   wire        step_is_burn = (step_q >= ST_BURN_A) && (step_q <= ST_BURN_Z);                   // [RL7]
   wire        step_is_eot  = (step_q >= ST_EOT_A) && (step_q <= ST_EOT_Z);                     // [RL9]
   wire [2:0]  tx_code      = step_is_burn ? otp_pkg::CODE_BURN :                               // [RL6]
                              step_is_eot ? otp_pkg::CODE_EOT :                                 // [RL12]
                              (step_q == ST_MARGIN_LD) ? otp_pkg::CODE_MARGIN :                 // [RL10]
                              otp_pkg::CODE_BLANK;                                              // [RL2] [RL11]
   wire [7:0]  tx_word      = step_is_burn ? word_q : 8'h00;                                    // [RL5]
   wire [22:0] write_hi     = {otp_pkg::PFX_WRITE, otp_pkg::TRIM_ADDR, tx_code, tx_word, 4'h0};
   wire [22:0] read_hi      = {otp_pkg::PFX_READ, otp_pkg::TRIM_ADDR, 15'h0000};                // [RL3]
   wire [22:0] frame_hi     = step_is_read ? read_hi : write_hi;
   wire [23:0] tx_frame     = {frame_hi, otp_pkg::odd_par(frame_hi)};                           // [RL15]
   wire [7:0]  rx_word      = rx_q[otp_pkg::R_WORD_MSB:otp_pkg::R_WORD_LSB];
   wire        rx_locked    = rx_q[otp_pkg::R_LOCK];
   wire        rx_par_ok    = otp_pkg::par_ok(rx_q);                                            // [RL15]
   wire        blank_ok     = (rx_word[otp_pkg::BLANK_MSB:otp_pkg::BLANK_LSB] == '0);           // [RL4]
   wire        verify_ok    = (rx_word == word_q) && rx_locked;                                 // [RL10] [RL11]
   wire        check_ok     = rx_par_ok && ((step_q == ST_BLANK_RD) ? blank_ok : verify_ok);
   wire [otp_pkg::CNT_W-1:0] wait_len = step_is_burn ? otp_pkg::burn_cyc(word_q, P_BURN_BIT_CYC) // [RL8]
                                        : otp_pkg::CNT_W'(P_EOT_CYC);                           // [RL9]

   assign SPI.sck     = sck_q;
   assign SPI.csn_n   = csn_n_q;
   assign SPI.sdi     = shift_q[23];
   assign O_BUSY      = busy_q;
   assign O_PASS      = pass_q;
   assign O_FAIL      = fail_q;
   assign O_FAIL_STEP = fstep_q;
   assign O_RD_DATA   = rd_q;

   always_ff @(posedge I_MCLK) begin
      sdo_s1_q <= SPI.sdo;
      sdo_s2_q <= sdo_s1_q;
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RESET) begin
         st_q    <= S_IDLE;
         step_q  <= ST_BLANK_LD;
         word_q  <= '0;
         shift_q <= '0;
         rx_q    <= '0;
         rd_q    <= '0;
         bit_q   <= '0;
         div_q   <= '0;
         wait_q  <= '0;
         sck_q   <= 1'b0;
         csn_n_q <= 1'b1;
         busy_q  <= 1'b0;
         pass_q  <= 1'b0;
         fail_q  <= 1'b0;
         fstep_q <= '0;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (I_START) begin
                  word_q <= I_WORD;                                                             // [RL5]
                  step_q <= ST_BLANK_LD;                                                        // [RL1]
                  busy_q <= 1'b1;
                  pass_q <= 1'b0;
                  fail_q <= 1'b0;
                  st_q   <= S_LOAD;
               end
            end
            S_LOAD: begin
               shift_q <= tx_frame;
               csn_n_q <= 1'b0;
               bit_q   <= '0;
               div_q   <= '0;
               st_q    <= S_SEND;
            end
            S_SEND: begin
               if (div_q == otp_pkg::HALF_M1) begin
                  div_q <= '0;
                  if (!sck_q) begin
                     sck_q <= 1'b1;
                     rx_q  <= {rx_q[22:0], sdo_s2_q};                                           // [RL3]
                  end else begin
                     sck_q   <= 1'b0;
                     shift_q <= {shift_q[22:0], 1'b0};
                     if (bit_q == otp_pkg::LAST_BIT) begin
                        csn_n_q <= 1'b1;
                        wait_q  <= otp_pkg::GAP_CYC;
                        st_q    <= S_GAP;
                     end else begin
                        bit_q <= bit_q + 5'h1;
                     end
                  end
               end else begin
                  div_q <= div_q + 3'h1;
               end
            end
            S_GAP: begin
               if (wait_q != '0) begin
                  wait_q <= wait_q - otp_pkg::CNT_W'(1);
               end else if (step_is_burn || step_is_eot) begin
                  wait_q <= wait_len;                                                           // [RL8] [RL9]
                  st_q   <= S_WAIT;
               end else begin
                  st_q <= S_CHECK;
               end
            end
            S_WAIT: begin
               if (wait_q != '0) begin
                  wait_q <= wait_q - otp_pkg::CNT_W'(1);
               end else begin
                  st_q <= S_CHECK;
               end
            end
            S_CHECK: begin
               if (step_is_read) begin
                  rd_q <= rx_q;
               end
               if (step_is_read && !check_ok) begin
                  fail_q  <= 1'b1;                                                              // [RL4]
                  fstep_q <= step_q;
                  st_q    <= S_DONE;
               end else if (step_q == ST_FINAL_RD) begin
                  pass_q <= 1'b1;
                  st_q   <= S_DONE;
               end else begin
                  step_q <= step_q + 4'h1;                                                      // [RL1] [RL7]
                  st_q   <= S_LOAD;
               end
            end
            S_DONE: begin
               busy_q <= 1'b0;
               st_q   <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: test/otp_trim_props.sv */
// link checks on the serial lines between trimming master and device
`timescale 1ns/10ps
module otp_trim_props (
   input  wire logic I_MCLK,
   input  wire logic I_RESET,
   input  wire logic sck,
   input  wire logic csn_n,
   input  wire logic sdi,
   input  wire logic sdo_o,
   input  wire logic sdo_oe,
   input  wire logic sdo
);
   logic        sck_q;
   logic [4:0]  nbit_q;
   logic [4:0]  gap_q;
   logic [23:0] txs_q;
   logic [23:0] rxs_q;
   wire         rise = sck & ~sck_q;
   wire         wr   = ~txs_q[22];

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RESET);

   // frame bit count, deselect gap and captured frames
   always_ff @(posedge I_MCLK) begin
      sck_q  <= sck;
      nbit_q <= csn_n ? 5'h00 : nbit_q + {4'h0, rise};
      gap_q  <= I_RESET ? 5'h1f : (!csn_n ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1f});
      if (rise && !csn_n) begin
         txs_q <= {txs_q[22:0], sdi};
         rxs_q <= {rxs_q[22:0], sdo_o};
      end
   end

   sequence s_hi8;
      sck [*8] ##1 !sck;
   endsequence
   sequence s_oe_on;
      ##[1:4] sdo_oe;
   endsequence

   AST_GAP: assert property ($fell(csn_n) |-> gap_q >= 5'h10)
      else $error("deselect gap too short");
   AST_SCK_HI: assert property ($rose(sck) |-> s_hi8)
      else $error("clock high phase wrong");
   AST_SCK_LO: assert property ($fell(sck) |-> (!sck) [*8])
      else $error("clock low phase too short");
   AST_SDI_HOLD: assert property ($rose(sck) |-> $stable(sdi) [*8])
      else $error("data moved while clock high");
   AST_LEN: assert property ($rose(csn_n) |-> nbit_q == 5'h18)
      else $error("frame not 24 bits");
   AST_PAR_TX: assert property ($rose(csn_n) |-> ^txs_q)
      else $error("command parity not odd");
   AST_PAR_RX: assert property ($rose(csn_n) |-> ^rxs_q)
      else $error("answer parity not odd");
   AST_ADDR: assert property ($rose(csn_n) |-> !txs_q[23] && txs_q[21:16] == 6'h3e)
      else $error("wrong prefix or address");
   AST_READ: assert property ($rose(csn_n) && !wr |-> txs_q[15:1] == 15'h0000)
      else $error("read frame not empty");
   AST_CODE: assert property ($rose(csn_n) && wr |-> txs_q[15:13] inside {3'h2, 3'h3, 3'h4, 3'h7})
      else $error("unexpected operation code");
   AST_PAYLOAD: assert property ($rose(csn_n) && wr |->
      txs_q[4:1] == 4'h0 && (txs_q[15:13] == 3'h4 || txs_q[12:5] == 8'h00))
      else $error("payload outside burn word");
   AST_OE_ON: assert property ($fell(csn_n) |-> s_oe_on)
      else $error("answer not driven");
   AST_OE_OFF: assert property ($rose(csn_n) |-> ##[1:4] !sdo_oe)
      else $error("answer line not released");
   AST_IDLE: assert property (csn_n [*3] |-> !sdo_oe && sdo)
      else $error("released line not high");
endmodule

/* File: test/tb.sv */
// testbench: master and device joined, plus a bench-driven second device
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
   localparam int BIT_C = 40;
   localparam int EOT_C = 60;
   logic        I_MCLK  = 1'b0;
   logic        I_RESET = 1'b1;
   logic        i_start = 1'b0;
   logic [7:0]  i_word  = 8'h00;
   logic        busy, pass, fail, lock, bbusy, ferr, lock2, bbusy2, ferr2;
   logic [3:0]  step;
   logic [23:0] rd;
   logic [7:0]  tword;
   int          n_fail  = 0;
   int          n_tests = 0;
   int          cyc     = 0;
   int          nerr1   = 0;
   int          nerr2   = 0;
   int          blen    = 0;
   int          bq[$];
   otp_spi_if   spi ();
   otp_spi_if   spi2 ();

   otp_trim_host #(.P_BURN_BIT_CYC(BIT_C), .P_EOT_CYC(EOT_C)) otp_trim_host_i (.I_MCLK(I_MCLK),
      .I_RESET(I_RESET), .I_START(i_start), .I_WORD(i_word), .O_BUSY(busy), .O_PASS(pass), .O_FAIL(fail),
      .O_FAIL_STEP(step), .O_RD_DATA(rd), .SPI(spi.host));
   otp_trim_dev #(.P_BURN_BIT_CYC(BIT_C), .P_EOT_CYC(EOT_C)) otp_trim_dev_i (.I_MCLK(I_MCLK),
      .I_RESET(I_RESET), .O_TRIM_WORD(tword), .O_LOCKED(lock), .O_BURN_BUSY(bbusy), .O_FRAME_ERR(ferr),
      .SPI(spi.device));
   otp_trim_dev #(.P_BURN_BIT_CYC(BIT_C), .P_EOT_CYC(EOT_C)) otp_trim_dev_i2 (.I_MCLK(I_MCLK),
      .I_RESET(I_RESET), .O_TRIM_WORD(), .O_LOCKED(lock2), .O_BURN_BUSY(bbusy2), .O_FRAME_ERR(ferr2),
      .SPI(spi2.device));
   otp_trim_props otp_trim_props_i (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .sck(spi.sck), .csn_n(spi.csn_n),
      .sdi(spi.sdi), .sdo_o(spi.sdo_o), .sdo_oe(spi.sdo_oe), .sdo(spi.sdo));

   always #2 I_MCLK = ~I_MCLK;

   // error pulses, burn lengths, run ceiling of about two and a half times the planned cycles
   always @(negedge I_MCLK) begin
      cyc++;
      nerr1 += ferr;
      nerr2 += ferr2;
      if (bbusy) blen++;
      else if (blen != 0) begin
         bq.push_back(blen);
         blen = 0;
      end
      if (cyc == 70000) begin
         n_fail++;
         report_and_stop();
      end
   end

   function automatic logic [23:0] img(input logic [2:0] c, input logic [7:0] w, input logic l);
      logic [23:0] f;
      f = {c, w, l, 12'h000};
      f[0] = ~^f[23:1];
      return f;
   endfunction

   function automatic logic [23:0] frm(input logic [1:0] p, input logic [2:0] c, input logic [7:0] w);
      logic [23:0] f;
      f = {p, otp_pkg::TRIM_ADDR, c, w, 5'h00};
      f[0] = ~^f[23:1];
      return f;
   endfunction

   task automatic rst();
      I_RESET = 1'b1;
      repeat (20) @(negedge I_MCLK);
      I_RESET = 1'b0;
      repeat (20) @(negedge I_MCLK);
      bq.delete();
   endtask

   task automatic flow(input logic [7:0] w);
      i_word = w;
      i_start = 1'b1;
      @(negedge I_MCLK);
      i_start = 1'b0;
      for (int k = 0; k < 30000 && busy !== 1'b0; k++) @(negedge I_MCLK);
   endtask

   // second link: bench plays the master, nb bits, answer captured
   task automatic send(input logic [23:0] f, input int nb, output logic [23:0] rx);
      rx = 24'h000000;
      spi2.csn_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi2.sdi = f[23-i];
         repeat (8) @(negedge I_MCLK);
         spi2.sck = 1'b1;
         rx = {rx[22:0], spi2.sdo};
         repeat (8) @(negedge I_MCLK);
         spi2.sck = 1'b0;
      end
      repeat (8) @(negedge I_MCLK);
      spi2.csn_n = 1'b1;
      spi2.sdi = ~spi2.sdi;
      repeat (20) @(negedge I_MCLK);
   endtask

   task automatic t_faults();
      logic [23:0] rx;
      int          e0;
      rst();
      e0 = nerr2;
      `CHK("sdo idle", 1'b1, spi2.sdo)
      send(frm(2'h0, otp_pkg::CODE_BLANK, 8'h00), 23, rx);
      `CHK("short frame", e0 + 1, nerr2)
      send(frm(2'h0, otp_pkg::CODE_BLANK, 8'h00) ^ 24'h000001, 24, rx);
      `CHK("bad parity", e0 + 2, nerr2)
      send(frm(2'h0, 3'h5, 8'h00), 24, rx);
      send(frm(2'h1, 3'h0, 8'h00), 24, rx);
      `CHK("image", img(3'h0, otp_pkg::RESET_WORD, 1'b0), rx)
      send(frm(2'h0, otp_pkg::CODE_STD, 8'h00), 24, rx);
      send(frm(2'h1, 3'h0, 8'h00), 24, rx);
      `CHK("standard load", img(otp_pkg::CODE_STD, 8'h00, 1'b0), rx)
      send(frm(2'h0, otp_pkg::CODE_EOT, 8'h00), 24, rx);
      for (int k = 0; k < 400 && bbusy2 !== 1'b0; k++) @(negedge I_MCLK);
      `CHK("locked", 1'b1, lock2)
      send(frm(2'h0, otp_pkg::CODE_BURN, 8'hff), 24, rx);
      `CHK("burn when locked", 1'b0, bbusy2)
      send(frm(2'h1, 3'h0, 8'h00), 24, rx);
      `CHK("locked image", img(otp_pkg::CODE_EOT, 8'h00, 1'b1), rx)
      $display("test faults done");
   endtask

   task automatic t_pass(input logic [7:0] w);
      int n;
      n = 0;
      for (int i = 0; i < 8; i++) n += w[i];
      rst();
      flow(w);
      `CHK("pass", 1'b1, pass)
      `CHK("fail", 1'b0, fail)
      `CHK("trim word", w, tword)
      `CHK("lock", 1'b1, lock)
      `CHK("last read", img(otp_pkg::CODE_BLANK, w, 1'b1), rd)
      `CHK("burn count", 6, bq.size())
      for (int i = 0; i < 6 && i < bq.size(); i++)
         `CHK("burn time", (i < 3) ? otp_pkg::BURN_BASE_CYC + BIT_C * n : EOT_C, bq[i])
      $display("test flow word %h done", w);
   endtask

   task automatic t_again();
      bq.delete();
      flow(8'ha5);
      `CHK("pass", 1'b0, pass)
      `CHK("fail", 1'b1, fail)
      `CHK("step", 4'h1, step)
      `CHK("blank read", img(otp_pkg::CODE_BLANK, 8'ha5, 1'b1), rd)
      `CHK("no burn", 0, bq.size())
      $display("test reprogram refused done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      spi2.sck = 1'b0;
      spi2.csn_n = 1'b1;
      spi2.sdi = 1'b0;
      t_faults();
      t_pass(8'ha5);
      t_again();
      t_pass(8'hff);
      t_pass(8'h00);
      `CHK("frame errors", 0, nerr1)
      report_and_stop();
   end
endmodule
